//--- hdl/cpf_pkg.sv
// Purpose: Shared constants and types of the chain framer.
// Assumes: Bytes travel most significant bit first.
// Notes: Check code is 15 bits, sent as a 16-bit word.
package cpf_pkg;
  // Check code generator
  localparam int CRC_W = 15;
  localparam logic [14:0] CRC_SEED = 15'h0010;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  // Framing sizes
  localparam int BYTE_W = 8;
  localparam int CMD_BITS = 16;
  localparam int CHK_BITS = 16;
  localparam int GROUP_BYTES = 6;
  localparam int FIFO_DEPTH = 8;
  // Synchroniser idle levels: mode, lone, stack data, data, select, clock
  localparam logic [5:0] SYNC_IDLE = 6'h0f;
  // Framer states
  typedef enum logic [9:0] {
    CPF_IDLE = 10'h001,
    CPF_CMD = 10'h002,
    CPF_CHK = 10'h004,
    CPF_DEC = 10'h008,
    CPF_WRITE = 10'h010,
    CPF_READ = 10'h020,
    CPF_POLL = 10'h040,
    CPF_VERIFY = 10'h080,
    CPF_PUSH = 10'h100,
    CPF_DRAIN = 10'h200
  } cpf_state_t;
endpackage

//--- hdl/cpf_crc15.sv
// Purpose: Bit-serial 15-bit check code register.
// Assumes: One bit per shift strobe, in transmission order.
// Notes: Clear loads the seed; clear wins over shift.
`timescale 1ns/100ps
module cpf_crc15 (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic shift,
  input wire logic din,
  output logic [14:0] crc
);
  logic [14:0] crc_r;
  logic [14:0] crc_nxt;

  // One step: feedback term, shift up, xor taps
  function automatic logic [14:0] cpf_step(input logic [14:0] c, input logic d);
    logic crc_feedback_term;
    crc_feedback_term = d ^ c[14];
    cpf_step = {c[13:0], 1'b0} ^ (crc_feedback_term ? cpf_pkg::CRC_POLY : 15'h0000);
  endfunction

  // Next value
  always_comb begin
    crc_nxt = crc_r;
    if (clear) begin
      crc_nxt = cpf_pkg::CRC_SEED;
    end else if (shift) begin
      crc_nxt = cpf_step(crc_r, din);
    end
  end

  // Register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      crc_r <= cpf_pkg::CRC_SEED;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;
endmodule

//--- hdl/cpf_fifo.sv
// Purpose: Small first-in first-out buffer with valid and ready.
// Assumes: Single clock.
// Notes: Full stalls the writer through in_ready.
`timescale 1ns/100ps
module cpf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0] fill_r;
  logic [AW:0] fill_nxt;
  logic wr;
  logic rd;

  // Pointer and fill update
  always_comb begin
    wr = in_valid && (fill_r != (AW + 1)'(DEPTH));
    rd = out_ready && (fill_r != '0);
    wp_nxt = wr ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = rd ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    fill_nxt = fill_r + (AW + 1)'(wr) - (AW + 1)'(rd);
  end

  // Registers and storage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
      fill_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      fill_r <= fill_nxt;
      if (wr) begin
        mem_r[wp_r] <= in_data;
      end
    end
  end

  assign in_ready = (fill_r != (AW + 1)'(DEPTH));
  assign out_valid = (fill_r != '0);
  assign out_data = mem_r[rp_r];
endmodule

//--- hdl/cpf_chain_framer.sv
// Purpose: Host-side framing, check code and chain shifting of one stacked monitor.
// Assumes: Serial clock idles high, data sampled on its rising edge.
// Notes: All pins sampled by sys_clk through two flip-flops.
`timescale 1ns/100ps
module cpf_chain_framer #(
  parameter int GROUP_BYTES = cpf_pkg::GROUP_BYTES,
  parameter int FIFO_DEPTH = cpf_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic host_port_mode_select,
  input wire logic lone_device,
  input wire logic host_sck,
  input wire logic chip_select_n,
  input wire logic host_sdi,
  output logic host_sdo_o,
  output logic host_sdo_oe,
  output logic iso_reply_valid,
  output logic iso_reply_level,
  output logic stack_sck,
  output logic stack_cs_n,
  output logic stack_sdi,
  input wire logic stack_sdo,
  input wire logic conv_busy,
  input wire logic cmd_is_write,
  input wire logic cmd_is_read,
  input wire logic cmd_is_poll,
  input wire logic cmd_is_convert,
  input wire logic [GROUP_BYTES*8-1:0] rd_group_data,
  output logic [15:0] cmd_word,
  output logic cmd_valid,
  output logic cmd_pec_error,
  output logic conv_start,
  output logic data_pec_error,
  output logic wr_commit,
  output logic wr_byte_valid,
  input wire logic wr_byte_ready,
  output logic [7:0] wr_byte_data
);
  localparam int D = GROUP_BYTES * cpf_pkg::BYTE_W;
  localparam int W = D + cpf_pkg::CHK_BITS;
  localparam int CW = $clog2(W + 1);
  localparam logic [CW-1:0] CNT_CMD = CW'(cpf_pkg::CMD_BITS);
  localparam logic [CW-1:0] CNT_FRAME = CW'(cpf_pkg::CMD_BITS + cpf_pkg::CHK_BITS);
  localparam logic [CW-1:0] CNT_D = CW'(D);
  localparam logic [CW-1:0] CNT_W = CW'(W);
  localparam logic [CW-1:0] CNT_GB = CW'(GROUP_BYTES);
  localparam logic [CW-1:0] BYTE_MASK = CW'(cpf_pkg::BYTE_W - 1);

  // Pin synchronisers and edge history
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic sck_d_r;
  logic cs_d_r;
  logic sck_s;
  logic cs_s;
  logic sdi_s;
  logic up_s;
  logic lone_s;
  logic two_wire_s;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  // Framer state
  cpf_pkg::cpf_state_t state_r;
  cpf_pkg::cpf_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [31:0] frame_r;
  logic [31:0] frame_nxt;
  logic [W-1:0] win_r;
  logic [W-1:0] win_nxt;
  logic [W-1:0] tx_r;
  logic [W-1:0] tx_nxt;
  logic drop_r;
  logic drop_nxt;
  logic stage_r;
  logic stage_nxt;
  logic sdo_lvl_r;
  logic sdo_lvl_nxt;
  logic reply_v_r;
  logic reply_v_nxt;
  logic reply_l_r;
  logic reply_l_nxt;
  logic sck_o_r;
  logic cs_o_r;
  logic sdi_o_r;
  logic sdi_o_nxt;
  logic [15:0] cmd_word_r;
  logic [15:0] cmd_word_nxt;
  logic cmd_valid_r;
  logic cmd_valid_nxt;
  logic cmd_err_r;
  logic cmd_err_nxt;
  logic conv_r;
  logic conv_nxt;
  logic derr_r;
  logic derr_nxt;
  logic commit_r;
  logic commit_nxt;

  // Check code engines and write buffer hooks
  logic rx_clr;
  logic rx_en;
  logic rx_bit;
  logic tx_clr;
  logic tx_en;
  logic tx_bit;
  logic [14:0] rx_crc;
  logic [14:0] tx_crc;
  logic push;
  logic push_ready;
  logic [15:0] rx_chk;
  logic [15:0] tx_chk;
  logic status_now;

  assign {two_wire_s, lone_s, up_s, sdi_s, cs_s, sck_s} = sync2_r;
  assign rise = sck_s && !sck_d_r;
  assign fall = !sck_s && sck_d_r;
  assign cs_fall = !cs_s && cs_d_r;
  assign cs_rise = cs_s && !cs_d_r;
  // Check word: code shifted up with a zero below
  assign rx_chk = {rx_crc, 1'b0};
  assign tx_chk = {tx_crc, 1'b0};
  // Stack status: own idle and everything above idle
  assign status_now = !conv_busy && (lone_s || up_s);

  cpf_crc15 u_rx_crc (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(rx_clr),
    .shift(rx_en),
    .din(rx_bit),
    .crc(rx_crc)
  );

  cpf_crc15 u_tx_crc (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(tx_clr),
    .shift(tx_en),
    .din(tx_bit),
    .crc(tx_crc)
  );

  cpf_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(win_r[D-1 -: 8]),
    .out_valid(wr_byte_valid),
    .out_ready(wr_byte_ready),
    .out_data(wr_byte_data)
  );

  // Two-flop synchronisers; edges read the second stage only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_r <= cpf_pkg::SYNC_IDLE;
      sync2_r <= cpf_pkg::SYNC_IDLE;
      sck_d_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      sync1_r <= {host_port_mode_select, lone_device, stack_sdo, host_sdi,
                  chip_select_n, host_sck};
      sync2_r <= sync1_r;
      sck_d_r <= sck_s;
      cs_d_r <= cs_s;
    end
  end

  // Framer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    frame_nxt = frame_r;
    win_nxt = win_r;
    tx_nxt = tx_r;
    drop_nxt = drop_r;
    stage_nxt = stage_r;
    sdo_lvl_nxt = 1'b1;
    reply_v_nxt = 1'b0;
    reply_l_nxt = reply_l_r;
    sdi_o_nxt = sdi_s;
    cmd_word_nxt = cmd_word_r;
    cmd_valid_nxt = 1'b0;
    cmd_err_nxt = 1'b0;
    conv_nxt = 1'b0;
    derr_nxt = 1'b0;
    commit_nxt = 1'b0;
    rx_clr = 1'b0;
    rx_en = 1'b0;
    rx_bit = sdi_s;
    tx_clr = 1'b0;
    tx_en = 1'b0;
    tx_bit = tx_r[W-1];
    push = 1'b0;
    unique case (state_r)
      cpf_pkg::CPF_IDLE: begin
        if (cs_fall) begin
          state_nxt = cpf_pkg::CPF_CMD;
          cnt_nxt = '0;
          rx_clr = 1'b1;
        end
      end
      cpf_pkg::CPF_CMD, cpf_pkg::CPF_CHK: begin
        // Command bits pass straight up the stack
        sdi_o_nxt = sdi_s;
        if (rise) begin
          frame_nxt = {frame_r[30:0], sdi_s};
          cnt_nxt = cnt_r + 1'b1;
          rx_en = state_r == cpf_pkg::CPF_CMD;
          if (cnt_r == CNT_CMD - 1'b1) begin
            state_nxt = cpf_pkg::CPF_CHK;
          end
          if (cnt_r == CNT_FRAME - 1'b1) begin
            if ({frame_r[14:0], sdi_s} == rx_chk) begin
              cmd_word_nxt = frame_r[30:15];
              cmd_valid_nxt = 1'b1;
              state_nxt = cpf_pkg::CPF_DEC;
            end else begin
              cmd_err_nxt = 1'b1;
              state_nxt = cpf_pkg::CPF_DRAIN;
            end
          end
        end
      end
      cpf_pkg::CPF_DEC: begin
        cnt_nxt = '0;
        win_nxt = '0;
        drop_nxt = 1'b0;
        stage_nxt = 1'b0;
        if (cmd_is_convert) begin
          conv_nxt = 1'b1;
          state_nxt = cpf_pkg::CPF_POLL;
        end else if (cmd_is_poll) begin
          state_nxt = cpf_pkg::CPF_POLL;
        end else if (cmd_is_write) begin
          state_nxt = cpf_pkg::CPF_WRITE;
        end else if (cmd_is_read) begin
          tx_nxt = {rd_group_data, 16'h0000};
          tx_clr = 1'b1;
          state_nxt = cpf_pkg::CPF_READ;
        end else begin
          state_nxt = cpf_pkg::CPF_DRAIN;
        end
      end
      cpf_pkg::CPF_WRITE: begin
        // Window delays write data by one group and its check word before passing it up
        sdi_o_nxt = sdi_o_r;
        if (rise) begin
          win_nxt = {win_r[W-2:0], sdi_s};
          drop_nxt = win_r[W-1];
          if (cnt_r != CNT_W) begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        if (fall) begin
          sdi_o_nxt = drop_r;
        end
      end
      cpf_pkg::CPF_READ: begin
        sdo_lvl_nxt = sdo_lvl_r;
        if (rise) begin
          win_nxt = {win_r[W-2:0], up_s};
          drop_nxt = win_r[W-1];
        end
        if (fall) begin
          if (cnt_r < CNT_D) begin
            sdo_lvl_nxt = tx_r[W-1];
            tx_en = 1'b1;
            tx_nxt = {tx_r[W-2:0], 1'b0};
          end else if (cnt_r == CNT_D) begin
            sdo_lvl_nxt = tx_chk[15];
            tx_nxt = {tx_chk[14:0], {(W - 15){1'b0}}};
          end else if (cnt_r < CNT_W) begin
            sdo_lvl_nxt = tx_r[W-1];
            tx_nxt = {tx_r[W-2:0], 1'b0};
          end else begin
            sdo_lvl_nxt = drop_r;
          end
          if (cnt_r != CNT_W) begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      cpf_pkg::CPF_POLL: begin
        // Lone device follows busy at once; chained stage moves per clock
        if (lone_s) begin
          stage_nxt = status_now;
        end else if (rise) begin
          stage_nxt = status_now;
        end
        sdo_lvl_nxt = two_wire_s ? 1'b1 : stage_r;
        if (rise && two_wire_s) begin
          reply_v_nxt = 1'b1;
          reply_l_nxt = status_now;
        end
      end
      cpf_pkg::CPF_VERIFY: begin
        // Rotate the window through the code engine
        if (cnt_r == CNT_D) begin
          if (win_r[W-1 -: 16] == rx_chk) begin
            state_nxt = cpf_pkg::CPF_PUSH;
          end else begin
            derr_nxt = 1'b1;
            state_nxt = cpf_pkg::CPF_IDLE;
          end
          cnt_nxt = '0;
        end else begin
          rx_en = 1'b1;
          rx_bit = win_r[W-1];
          win_nxt = {win_r[W-2:0], win_r[W-1]};
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      cpf_pkg::CPF_PUSH: begin
        push = 1'b1;
        if (push_ready) begin
          win_nxt = {win_r[W-1:D], win_r[D-9:0], 8'h00};
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CNT_GB - 1'b1) begin
            commit_nxt = 1'b1;
            state_nxt = cpf_pkg::CPF_IDLE;
          end
        end
      end
      cpf_pkg::CPF_DRAIN: begin
        state_nxt = cpf_pkg::CPF_DRAIN;
      end
      default: begin
        state_nxt = cpf_pkg::CPF_IDLE;
      end
    endcase
    // Select rising ends the sequence in every state but CPF_VERIFY and CPF_PUSH, and releases data high
    if (cs_rise && state_r != cpf_pkg::CPF_VERIFY && state_r != cpf_pkg::CPF_PUSH) begin
      sdo_lvl_nxt = 1'b1;
      reply_v_nxt = 1'b0;
      state_nxt = cpf_pkg::CPF_IDLE;
      if (state_r == cpf_pkg::CPF_WRITE) begin
        // Commit only a whole, byte-aligned group
        if (cnt_r == CNT_W && (cnt_r & BYTE_MASK) == '0) begin
          state_nxt = cpf_pkg::CPF_VERIFY;
          cnt_nxt = '0;
          rx_clr = 1'b1;
        end else begin
          derr_nxt = 1'b1;
        end
      end
    end
  end

  // Framer registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= cpf_pkg::CPF_IDLE;
      cnt_r <= '0;
      frame_r <= '0;
      win_r <= '0;
      tx_r <= '0;
      drop_r <= 1'b0;
      stage_r <= 1'b0;
      sdo_lvl_r <= 1'b1;
      reply_v_r <= 1'b0;
      reply_l_r <= 1'b0;
      sck_o_r <= 1'b1;
      cs_o_r <= 1'b1;
      sdi_o_r <= 1'b1;
      cmd_word_r <= '0;
      cmd_valid_r <= 1'b0;
      cmd_err_r <= 1'b0;
      conv_r <= 1'b0;
      derr_r <= 1'b0;
      commit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      frame_r <= frame_nxt;
      win_r <= win_nxt;
      tx_r <= tx_nxt;
      drop_r <= drop_nxt;
      stage_r <= stage_nxt;
      sdo_lvl_r <= sdo_lvl_nxt;
      reply_v_r <= reply_v_nxt;
      reply_l_r <= reply_l_nxt;
      sck_o_r <= sck_s;
      cs_o_r <= cs_s;
      sdi_o_r <= sdi_o_nxt;
      cmd_word_r <= cmd_word_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      cmd_err_r <= cmd_err_nxt;
      conv_r <= conv_nxt;
      derr_r <= derr_nxt;
      commit_r <= commit_nxt;
    end
  end

  // Open-drain data: enable pulls the line low
  assign host_sdo_o = 1'b0;
  assign host_sdo_oe = !sdo_lvl_r;
  assign iso_reply_valid = reply_v_r;
  assign iso_reply_level = reply_l_r;
  assign stack_sck = sck_o_r;
  assign stack_cs_n = cs_o_r;
  assign stack_sdi = sdi_o_r;
  assign cmd_word = cmd_word_r;
  assign cmd_valid = cmd_valid_r;
  assign cmd_pec_error = cmd_err_r;
  assign conv_start = conv_r;
  assign data_pec_error = derr_r;
  assign wr_commit = commit_r;
endmodule

//--- bench/cpf_host_model.sv
// Purpose: Host controller model driving the four-wire link.
// Assumes: Link clock idles high; host changes data while it is low.
// Notes: Data line has a pull-up; read just before each rising clock.
`timescale 1ns/100ps
module cpf_host_model (
  input wire logic sys_clk,
  output logic host_sck,
  output logic chip_select_n,
  output logic host_sdi,
  input wire logic host_sdo_oe
);
  // Pins idle at time zero
  initial begin
    host_sck = 1'b1;
    chip_select_n = 1'b1;
    host_sdi = 1'b1;
  end
  // Half period of the link clock, 80 ns
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask
  // Select held low for a whole sequence; data line shows no stale bit after
  task automatic sel(input logic lo);
    chip_select_n = !lo;
    if (!lo) host_sdi = !host_sdi;
    half();
  endtask
  // One bit: data set with falling clock, line read before rising clock
  task automatic bit_x(input logic tx, output logic rx);
    host_sck = 1'b0;
    host_sdi = tx;
    half();
    rx = !host_sdo_oe;
    host_sck = 1'b1;
    half();
  endtask
  // One byte, most significant bit first
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
  endtask
endmodule

//--- bench/cpf_chain_framer_props.sv
// Purpose: Port-level checks of the chain framer.
// Assumes: Bench link clock half period of eight cycles.
// Notes: Bound to the framer from the bench top file.
`timescale 1ns/100ps
module cpf_chain_framer_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic host_port_mode_select,
  input wire logic host_sck,
  input wire logic chip_select_n,
  input wire logic host_sdo_oe,
  input wire logic iso_reply_valid,
  input wire logic stack_sck,
  input wire logic stack_cs_n,
  input wire logic stack_sdi,
  input wire logic cmd_is_convert,
  input wire logic cmd_valid,
  input wire logic cmd_pec_error,
  input wire logic conv_start,
  input wire logic data_pec_error,
  input wire logic wr_commit,
  input wire logic wr_byte_valid,
  input wire logic wr_byte_ready,
  input wire logic [7:0] wr_byte_data
);
  logic [3:0] since_ok_r, since_ok_nxt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Cycles since the last accepted command
  always_comb begin
    since_ok_nxt = since_ok_r;
    if (cmd_valid) since_ok_nxt = 4'h0;
    else if (since_ok_r != 4'hf) since_ok_nxt = since_ok_r + 4'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) since_ok_r <= 4'hf;
    else since_ok_r <= since_ok_nxt;
  end
  // Link edges seen at the pins
  sequence sck_fall_s;
    $fell(host_sck);
  endsequence
  sequence cs_rise_s;
    $rose(chip_select_n);
  endsequence
  reset_idle_a: assert property ($fell(reset) |-> !host_sdo_oe && stack_sck && stack_cs_n
    && stack_sdi && !wr_byte_valid) else $error("outputs not idle after reset");
  verdict_one_a: assert property (cmd_valid |-> !cmd_pec_error ##1 !cmd_valid
    && !cmd_pec_error) else $error("double command verdict");
  conv_cause_a: assert property (conv_start |-> cmd_valid || since_ok_r <= 4'h3)
    else $error("conversion start without accepted command");
  conv_follow_a: assert property (cmd_valid ##1 cmd_is_convert |-> ##[0:3] conv_start)
    else $error("convert command did not start conversion");
  select_release_a: assert property (chip_select_n [*8] |-> !host_sdo_oe)
    else $error("data line held low with select high");
  stack_clock_a: assert property (sck_fall_s |-> ##[2:4] !stack_sck)
    else $error("link clock not passed up the stack");
  stack_select_a: assert property (cs_rise_s |-> ##[2:4] stack_cs_n)
    else $error("select rise not passed up the stack");
  iso_reply_a: assert property (iso_reply_valid |-> host_port_mode_select && host_sck
    && !chip_select_n ##1 !iso_reply_valid) else $error("reply pulse out of place");
  buf_hold_a: assert property (wr_byte_valid && !wr_byte_ready |=> wr_byte_valid
    && $stable(wr_byte_data)) else $error("buffer output dropped while stalled");
  commit_clean_a: assert property (wr_commit |-> !data_pec_error ##1 !wr_commit)
    else $error("commit together with data check error");
endmodule

//--- bench/cpf_chain_framer_tb.sv
// Purpose: Self-checking bench of the chain framer.
// Assumes: Host model on the link pins; bench stands for the device above.
// Notes: A monitor counts output pulses; scenarios compare count deltas.
`timescale 1ns/100ps
module cpf_chain_framer_tb;
  logic sys_clk, reset, host_port_mode_select, lone_device, host_sck, chip_select_n;
  logic host_sdi, host_sdo_oe, iso_reply_valid, iso_reply_level, stack_sck, stack_cs_n;
  logic stack_sdi, stack_sdo, conv_busy, cmd_is_write, cmd_is_read, cmd_is_poll;
  logic cmd_is_convert, cmd_valid, cmd_pec_error, conv_start, data_pec_error, wr_commit;
  logic wr_byte_valid, wr_byte_ready;
  logic [47:0] rd_group_data;
  logic [15:0] cmd_word;
  logic [7:0] wr_byte_data;
  int failures, check_count, n_ok, n_err, n_conv, n_derr, n_commit, n_iso, n_hi;
  cpf_chain_framer dut (
    .sys_clk, .reset, .host_port_mode_select, .lone_device, .host_sck, .chip_select_n,
    .host_sdi, .host_sdo_o(), .host_sdo_oe, .iso_reply_valid, .iso_reply_level,
    .stack_sck, .stack_cs_n, .stack_sdi, .stack_sdo, .conv_busy, .cmd_is_write,
    .cmd_is_read, .cmd_is_poll, .cmd_is_convert, .rd_group_data, .cmd_word, .cmd_valid,
    .cmd_pec_error, .conv_start, .data_pec_error, .wr_commit, .wr_byte_valid,
    .wr_byte_ready, .wr_byte_data
  );
  cpf_host_model host (.sys_clk, .host_sck, .chip_select_n, .host_sdi, .host_sdo_oe);
  // Clock of 10 ns
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Count every one-cycle pulse
  always @(posedge sys_clk) begin
    n_ok += cmd_valid;
    n_err += cmd_pec_error;
    n_conv += conv_start;
    n_derr += data_pec_error;
    n_commit += wr_commit;
    n_iso += iso_reply_valid;
    n_hi += iso_reply_valid & iso_reply_level;
  end
  // Bit-serial check code, seed with only bit 4 set
  function automatic logic [14:0] crc_of(input logic [47:0] v, input int n);
    logic [14:0] c;
    logic f;
    c = 15'h0010;
    for (int i = n - 1; i >= 0; i--) begin
      f = v[i] ^ c[14];
      c = {c[13:0], f} ^ (f ? 15'h4598 : 15'h0000);
    end
    return c;
  endfunction
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Command frame: command bytes then check bytes
  task automatic send_cmd(input logic [15:0] c, input logic [15:0] flip);
    logic [7:0] rx;
    logic [15:0] w;
    w = {crc_of({32'h0, c}, 16), 1'b0} ^ flip;
    host.sel(1'b1);
    host.byte_x(c[15:8], rx);
    host.byte_x(c[7:0], rx);
    host.byte_x(w[15:8], rx);
    host.byte_x(w[7:0], rx);
  endtask
  // One data group, most significant byte first, then its check bytes
  task automatic send_group(input logic [47:0] d, input logic [15:0] flip);
    logic [7:0] rx;
    logic [15:0] w;
    w = {crc_of(d, 48), 1'b0} ^ flip;
    for (int i = 5; i >= 0; i--) host.byte_x(d[i*8 +: 8], rx);
    host.byte_x(w[15:8], rx);
    host.byte_x(w[7:0], rx);
  endtask
  task automatic pop(output logic [7:0] b);
    int n;
    n = 0;
    while (wr_byte_valid !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    b = wr_byte_data;
    wr_byte_ready = 1'b1;
    @(negedge sys_clk);
    wr_byte_ready = 1'b0;
  endtask
  // Known code value, good and corrupted command checks
  task automatic t_cmd();
    int ok0, err0;
    ok0 = n_ok;
    err0 = n_err;
    cmp({crc_of(48'h1, 16), 1'b0}, 16'h3d6e);
    send_cmd(16'h0001, 16'h0000);
    host.sel(1'b0);
    cmp(n_ok - ok0, 1);
    cmp(cmd_word, 16'h0001);
    send_cmd(16'h0001, 16'h0001);
    host.sel(1'b0);
    cmp(n_err - err0, 1);
    cmp(n_ok - ok0, 1);
  endtask
  // Lone device convert: line low while busy, high when done or deselected
  task automatic t_conv();
    int c0;
    c0 = n_conv;
    lone_device = 1'b1;
    conv_busy = 1'b1;
    cmd_is_convert = 1'b1;
    send_cmd(16'h0360, 16'h0000);
    repeat (4) @(negedge sys_clk);
    cmp(host_sdo_oe, 1);
    cmp(n_conv - c0, 1);
    conv_busy = 1'b0;
    repeat (6) @(negedge sys_clk);
    cmp(host_sdo_oe, 0);
    conv_busy = 1'b1;
    repeat (6) @(negedge sys_clk);
    cmp(host_sdo_oe, 1);
    host.sel(1'b0);
    cmp(host_sdo_oe, 0);
    conv_busy = 1'b0;
    cmd_is_convert = 1'b0;
  endtask
  // Chained four-wire poll: zero until status from above arrives
  task automatic t_poll_chain();
    logic rx;
    lone_device = 1'b0;
    stack_sdo = 1'b0;
    cmd_is_poll = 1'b1;
    send_cmd(16'h0714, 16'h0000);
    host.bit_x(1'b1, rx);
    cmp(rx, 0);
    stack_sdo = 1'b1;
    host.bit_x(1'b1, rx);
    cmp(rx, 0);
    host.bit_x(1'b1, rx);
    cmp(rx, 1);
    host.sel(1'b0);
    cmp(host_sdo_oe, 0);
    cmd_is_poll = 1'b0;
    lone_device = 1'b1;
  endtask
  // Two-wire poll: one reply per pulse, select high ends polling
  task automatic t_iso();
    logic rx;
    int i0, h0;
    host_port_mode_select = 1'b1;
    conv_busy = 1'b1;
    cmd_is_poll = 1'b1;
    i0 = n_iso;
    h0 = n_hi;
    send_cmd(16'h0714, 16'h0000);
    host.bit_x(1'b1, rx);
    host.bit_x(1'b1, rx);
    cmp(n_iso - i0, 2);
    cmp(n_hi - h0, 0);
    conv_busy = 1'b0;
    host.bit_x(1'b1, rx);
    cmp(n_iso - i0, 3);
    cmp(n_hi - h0, 1);
    host.sel(1'b0);
    host.bit_x(1'b1, rx);
    cmp(n_iso - i0, 3);
    cmd_is_poll = 1'b0;
    host_port_mode_select = 1'b0;
  endtask
  // Read: own group then its check bytes
  task automatic t_read();
    logic [7:0] b;
    logic [15:0] w;
    cmd_is_read = 1'b1;
    rd_group_data = 48'ha1b2c3d4e5f6;
    w = {crc_of(48'ha1b2c3d4e5f6, 48), 1'b0};
    send_cmd(16'h0002, 16'h0000);
    for (int i = 5; i >= 0; i--) begin
      host.byte_x(8'hff, b);
      cmp(b, rd_group_data[i*8 +: 8]);
    end
    host.byte_x(8'hff, b);
    cmp(b, w[15:8]);
    host.byte_x(8'hff, b);
    cmp(b, w[7:0]);
    host.sel(1'b0);
    cmd_is_read = 1'b0;
  endtask
  // Write: good group lands in order and commits; bad group flagged
  task automatic t_write();
    logic [7:0] b;
    logic [47:0] d;
    int m0, e0;
    d = 48'h0123456789ab;
    m0 = n_commit;
    e0 = n_derr;
    cmd_is_write = 1'b1;
    send_cmd(16'h0001, 16'h0000);
    send_group(d, 16'h0000);
    host.sel(1'b0);
    for (int i = 5; i >= 0; i--) begin
      pop(b);
      cmp(b, d[i*8 +: 8]);
    end
    repeat (4) @(negedge sys_clk);
    cmp(n_commit - m0, 1);
    send_cmd(16'h0001, 16'h0000);
    send_group(d, 16'h0100);
    host.sel(1'b0);
    repeat (60) @(negedge sys_clk);
    cmp(n_derr - e0, 1);
    cmp(n_commit - m0, 1);
    cmd_is_write = 1'b0;
  endtask
  // Reset, idle checks, then every scenario
  initial begin
    reset = 1'b1;
    host_port_mode_select = 1'b0;
    lone_device = 1'b1;
    stack_sdo = 1'b1;
    conv_busy = 1'b0;
    cmd_is_write = 1'b0;
    cmd_is_read = 1'b0;
    cmd_is_poll = 1'b0;
    cmd_is_convert = 1'b0;
    rd_group_data = '0;
    wr_byte_ready = 1'b0;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp(host_sdo_oe, 0);
    cmp(stack_cs_n, 1);
    t_cmd();
    t_conv();
    t_poll_chain();
    t_iso();
    t_read();
    t_write();
    finish_test();
  end
  // Watchdog
  initial begin
    #500000;
    failures++;
    finish_test();
  end
endmodule
bind cpf_chain_framer cpf_chain_framer_props props (.sys_clk, .reset, .host_port_mode_select,
  .host_sck, .chip_select_n, .host_sdo_oe, .iso_reply_valid, .stack_sck, .stack_cs_n,
  .stack_sdi, .cmd_is_convert, .cmd_valid, .cmd_pec_error, .conv_start, .data_pec_error,
  .wr_commit, .wr_byte_valid, .wr_byte_ready, .wr_byte_data);
